// *** design/qpis_pkg.sv ***
// package: phase encodings, oscillator modes, widths and reset values
package qpis_pkg;
    localparam int PHASE_COUNT = 4;
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam int PC_WIDTH = 11;
    localparam int INSTR_WIDTH = 12;
    localparam int DATA_WIDTH = 8;
    localparam int DADDR_WIDTH = 7;
    localparam logic [10:0] PC_RESET = 11'h7ff;
    localparam logic [11:0] INSTR_NOP = 12'h000;

    // oscillator select field values
    typedef enum logic [1:0] {
        QPIS_OSC_LP = 2'h0,
        QPIS_OSC_XT = 2'h1,
        QPIS_OSC_HS = 2'h2,
        QPIS_OSC_RC = 2'h3
    } qpis_osc_e;

    typedef enum logic [3:0] {
        QPIS_PH1 = 4'h1,
        QPIS_PH2 = 4'h2,
        QPIS_PH3 = 4'h4,
        QPIS_PH4 = 4'h8
    } qpis_phase_e;
endpackage

// *** design/qpis_phase_if.sv ***
// interface: phase strobes shared between phase generator and sequencer
`timescale 1ns/1ns
interface qpis_phase_if;
    logic phaseOne;
    logic phaseTwo;
    logic phaseThree;
    logic phaseFour;
    modport gen (output phaseOne, output phaseTwo, output phaseThree, output phaseFour);
    modport use_ (input phaseOne, input phaseTwo, input phaseThree, input phaseFour);
endinterface

// *** design/qpis_phase_gen.sv ***
// module: divide-by-four phase generator, one-hot state
`timescale 1ns/1ns
module qpis_phase_gen
    import qpis_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    qpis_phase_if.gen ph
);
    qpis_phase_e phase_r;
    qpis_phase_e phase_nxt;

    // ring of four states, one per input clock
    always_comb begin
        case (phase_r)
            QPIS_PH1: phase_nxt = QPIS_PH2;
            QPIS_PH2: phase_nxt = QPIS_PH3;
            QPIS_PH3: phase_nxt = QPIS_PH4;
            QPIS_PH4: phase_nxt = QPIS_PH1;
            default: phase_nxt = QPIS_PH1;
        endcase
    end

    // reset parks at phase_one so it is the first phase after release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= QPIS_PH1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // one-hot decode gives non-overlapping strobes
    assign ph.phaseOne = (phase_r == QPIS_PH1);
    assign ph.phaseTwo = (phase_r == QPIS_PH2);
    assign ph.phaseThree = (phase_r == QPIS_PH3);
    assign ph.phaseFour = (phase_r == QPIS_PH4);
endmodule // qpis_phase_gen

// *** design/qpis_sequencer.sv ***
// top: four-phase instruction cycle and fetch/execute pipeline sequencer
`timescale 1ns/1ns
module qpis_sequencer
#(
    parameter int PcWidth = qpis_pkg::PC_WIDTH,
    parameter int InstrWidth = qpis_pkg::INSTR_WIDTH
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] oscillatorSelectBits,
    output logic [PcWidth-1:0] progAddr,
    input wire logic [InstrWidth-1:0] progData,
    output logic [InstrWidth-1:0] instrWord,
    output logic instrValid,
    input wire logic pcLoad,
    input wire logic [PcWidth-1:0] pcTarget,
    output logic dataRead,
    output logic dataWrite,
    input wire logic execWantsWrite,
    output logic phaseOne,
    output logic phaseTwo,
    output logic phaseThree,
    output logic phaseFour,
    output logic cycleStart,
    output logic executeActive,
    output logic flushActive,
    output logic lowPowerCrystalMode,
    output logic crystalResonatorMode,
    output logic highSpeedCrystalMode,
    output logic resistorCapacitorMode
);
    import qpis_pkg::*;

    qpis_phase_if ph ();

    qpis_phase_gen u_phase (
        .clk(clk),
        .resetn(resetn),
        .ph(ph)
    );

    // local copies of the four strobes, read by every stage below
    logic phOne;
    logic phTwo;
    logic phThree;
    logic phFour;

    // unpack the shared strobes once
    assign phOne = ph.phaseOne;
    assign phTwo = ph.phaseTwo;
    assign phThree = ph.phaseThree;
    assign phFour = ph.phaseFour;

    // strobes leave the block as decoded, one cycle each
    assign phaseOne = phOne;
    assign phaseTwo = phTwo;
    assign phaseThree = phThree;
    assign phaseFour = phFour;
    // a new instruction cycle opens with phase_one
    assign cycleStart = phOne;

    // program counter and its redirect
    logic [PcWidth-1:0] pc_r;
    logic [PcWidth-1:0] pc_nxt;
    logic [PcWidth-1:0] pcStep;
    logic [PcWidth-1:0] jumpTarget_r;
    logic [PcWidth-1:0] jumpTarget_nxt;
    logic jumpPending_r;
    logic jumpPending_nxt;

    // fetch stage
    logic [InstrWidth-1:0] fetch_r;
    logic [InstrWidth-1:0] fetch_nxt;
    logic fetchValid_r;
    logic fetchValid_nxt;

    // execute stage
    logic [InstrWidth-1:0] ir_r;
    logic [InstrWidth-1:0] ir_nxt;
    logic irValid_r;
    logic irValid_nxt;

    // slot qualifiers
    logic takeJump;
    logic execSlot;
    logic readSlot;
    logic writeSlot;

    // pcLoad sampled at phase_four of an execute; redirect applies next phase_one
    // requests in other phases, or from a flushed slot, are ignored
    assign takeJump = phFour && irValid_r && pcLoad;

    assign pcStep = pc_r + PcWidth'(1);
    // redirect pc
    // the target replaces the step, so a jump never lands one word late
    assign pc_nxt = jumpPending_r ? jumpTarget_r : pcStep;

    // program counter steps once per cycle, in phase_one only
    // reset value wraps to zero on the first step
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pc_r <= PcWidth'(PC_RESET);
        end else if (phOne) begin
            pc_r <= pc_nxt;
        end
    end

    // jump latch, held from phase_four to the following phase_one
    // set wins over the clear, though the two never meet in one cycle
    assign jumpPending_nxt = takeJump ? 1'b1 : (phOne ? 1'b0 : jumpPending_r);
    assign jumpTarget_nxt = takeJump ? pcTarget : jumpTarget_r;

    // pending flag for the redirect
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            jumpPending_r <= 1'b0;
        end else begin
            jumpPending_r <= jumpPending_nxt;
        end
    end

    // target kept until the phase_one that applies it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            jumpTarget_r <= '0;
        end else begin
            jumpTarget_r <= jumpTarget_nxt;
        end
    end

    // fetch capture
    // the word is taken only at phase_four, once the memory has settled
    assign fetch_nxt = phFour ? progData : fetch_r;
    // discard prefetch
    // a redirect seen at the same edge marks the prefetched word as dead
    assign fetchValid_nxt = phFour ? !takeJump : fetchValid_r;

    // prefetch buffer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetch_r <= InstrWidth'(INSTR_NOP);
        end else begin
            fetch_r <= fetch_nxt;
        end
    end

    // prefetch validity, empty until the first fetch completes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetchValid_r <= 1'b0;
        end else begin
            fetchValid_r <= fetchValid_nxt;
        end
    end

    // overlapped stages
    // instruction register loads at phase_one while the next fetch begins
    // a dead prefetch enters as a no-op, giving the jump its second cycle
    assign ir_nxt = phOne ? (fetchValid_r ? fetch_r : InstrWidth'(INSTR_NOP)) : ir_r;
    assign irValid_nxt = phOne ? fetchValid_r : irValid_r;

    // current instruction, stands for a whole cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ir_r <= InstrWidth'(INSTR_NOP);
        end else begin
            ir_r <= ir_nxt;
        end
    end

    // slot validity, low in the first slot after reset and after a jump
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irValid_r <= 1'b0;
        end else begin
            irValid_r <= irValid_nxt;
        end
    end

    // address and instruction leave straight from flops
    assign progAddr = pc_r;
    assign instrWord = ir_r;
    assign instrValid = irValid_r;
    // flushed slot executes as a forced no-op
    assign flushActive = !irValid_r;

    assign execSlot = phTwo || phThree || phFour;
    assign executeActive = irValid_r && execSlot;

    // data phases
    // a flushed slot touches no data memory
    assign readSlot = irValid_r && phTwo;
    assign writeSlot = irValid_r && phFour;
    assign dataRead = readSlot;
    assign dataWrite = writeSlot && execWantsWrite;

    // oscillator mode
    // decode only; the analogue oscillator itself lives outside this block
    // exactly one mode output is high for any select value
    assign lowPowerCrystalMode = (oscillatorSelectBits == QPIS_OSC_LP);
    assign crystalResonatorMode = (oscillatorSelectBits == QPIS_OSC_XT);
    assign highSpeedCrystalMode = (oscillatorSelectBits == QPIS_OSC_HS);
    assign resistorCapacitorMode = (oscillatorSelectBits == QPIS_OSC_RC);
endmodule // qpis_sequencer

// *** sim/qpis_sequencer_props.sv ***
// checker: phase order, pipeline and strobe timing
`timescale 1ns/1ns
module qpis_sequencer_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [10:0] progAddr,
    input wire logic [11:0] progData,
    input wire logic [11:0] instrWord,
    input wire logic instrValid,
    input wire logic pcLoad,
    input wire logic [10:0] pcTarget,
    input wire logic dataRead,
    input wire logic dataWrite,
    input wire logic execWantsWrite,
    input wire logic phaseOne,
    input wire logic phaseTwo,
    input wire logic phaseThree,
    input wire logic phaseFour,
    input wire logic executeActive,
    input wire logic cycleStart,
    input wire logic flushActive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // plain slot end and redirect slot end
    sequence sFetch; phaseFour && !(pcLoad && instrValid) ##1 phaseOne; endsequence
    sequence sJump; phaseFour && pcLoad && instrValid ##1 phaseOne; endsequence
    a_phase_rotate: assert property (phaseOne |=> phaseTwo ##1 phaseThree ##1 phaseFour ##1 phaseOne)
        else $error("phase order");
    a_reset_first: assert property ($rose(resetn) |-> phaseOne)
        else $error("first phase");
    a_pc_step: assert property (sFetch |=> progAddr == $past(progAddr) + 11'h1)
        else $error("pc step");
    a_word_capture: assert property (sFetch |=> instrValid && instrWord == $past(progData, 2))
        else $error("word capture");
    a_jump_flush: assert property (sJump |=> progAddr == $past(pcTarget, 2) && !instrValid && instrWord == 12'h0)
        else $error("jump flush");
    a_exec_span: assert property (instrValid && phaseTwo |-> executeActive [*3])
        else $error("exec span");
    a_read_phase: assert property (dataRead == (instrValid && phaseTwo))
        else $error("read strobe");
    a_write_phase: assert property (dataWrite == (instrValid && phaseFour && execWantsWrite))
        else $error("write strobe");
    a_flush_flag: assert property (flushActive != instrValid)
        else $error("flush flag");
    a_start_strobe: assert property (cycleStart == phaseOne)
        else $error("cycle start");
endmodule // qpis_sequencer_props
bind qpis_sequencer qpis_sequencer_props i_qpis_sequencer_props (.*);

// *** sim/qpis_prog_mem.sv ***
// program memory model for the sequencer
`timescale 1ns/1ns
module qpis_prog_mem (
    input wire logic [10:0] progAddr,
    input wire logic phaseFour,
    output logic [11:0] progData
);
    // valid only in phase_four, so an early sample sees junk
    assign progData = phaseFour ? {1'b1, progAddr} ^ 12'h5a5 : ~({1'b1, progAddr} ^ 12'h5a5);
endmodule // qpis_prog_mem

// *** sim/qpis_sequencer_tb.sv ***
// testbench: reset, oscillator decode, flow and jump
`timescale 1ns/1ns
module qpis_sequencer_tb;
    import qpis_pkg::*;
    logic clk = 0, resetn = 0, pcLoad = 0, execWantsWrite = 1, iv, rd, wr, p1, p2, p3, p4;
    logic [1:0] oscSel = 0;
    logic [3:0] osc;
    logic [10:0] pcTarget = 0, pa, progAddr;
    logic [11:0] progData, ir;
    int nErrors = 0, nChecks = 0;
    qpis_sequencer i_qpis_sequencer (.clk(clk), .resetn(resetn), .oscillatorSelectBits(oscSel), .progAddr(progAddr),
        .progData(progData), .instrWord(ir), .instrValid(iv), .pcLoad(pcLoad), .pcTarget(pcTarget), .dataRead(rd),
        .dataWrite(wr), .execWantsWrite(execWantsWrite), .phaseOne(p1), .phaseTwo(p2), .phaseThree(p3),
        .phaseFour(p4), .cycleStart(), .executeActive(), .flushActive(), .lowPowerCrystalMode(osc[0]),
        .crystalResonatorMode(osc[1]), .highSpeedCrystalMode(osc[2]), .resistorCapacitorMode(osc[3]));
    qpis_prog_mem i_qpis_prog_mem (.progAddr(progAddr), .phaseFour(p4), .progData(progData));
    // expected word, kept apart from the model
    function automatic logic [11:0] w(input logic [10:0] a);
        return {1'b1, a} ^ 12'h5a5;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded only by the watchdog
    task automatic wp(input logic [3:0] m);
        do @(negedge clk); while ({p4, p3, p2, p1} !== m);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset;
        repeat (3) @(negedge clk);
        chk({p4, p3, p2, p1}, QPIS_PH1);
        chk(progAddr, PC_RESET);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) oscSel <= i[1:0];
            @(negedge clk) chk(osc, 4'h1 << i);
        end
    endtask
    // skip the empty first slot, then one word per cycle
    task automatic t_seq;
        pa = 11'h000;
        wp(QPIS_PH1);
        wp(QPIS_PH1);
        for (int k = 0; k < 4; k++) begin
            wp(QPIS_PH2);
            chk(progAddr, pa + 11'h1);
            chk({iv, ir}, {1'b1, w(pa)});
            chk(rd, 1);
            @(posedge clk) execWantsWrite <= k[0];
            wp(QPIS_PH4);
            chk(wr, k[0]);
            pa = progAddr;
        end
    endtask
    task automatic t_jump;
        wp(QPIS_PH3);
        @(posedge clk) pcLoad <= 1;
        pcTarget <= 11'h123;
        @(posedge clk) pcLoad <= 0;
        wp(QPIS_PH2);
        chk({iv, ir}, 0);
        chk(progAddr, 11'h123);
        wp(QPIS_PH2);
        chk({iv, ir}, {1'b1, w(11'h123)});
    endtask
    initial forever #5 clk = ~clk;
    // reset low for twenty edges
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1;
    end
    initial begin
        t_reset();
        @(posedge resetn);
        t_seq();
        t_jump();
        conclude();
    end
    // run needs well under a hundred cycles
    initial begin
        #20000;
        nErrors++;
        conclude();
    end
endmodule // qpis_sequencer_tb
